// [dsc_decoder.sv]
/*
  Serial command decoder and double-buffered code and settings registers of an
  eight-channel DAC. Link pins are sampled by mclk_i; the serial clock must
  run well below a quarter of mclk_i so that each edge is seen.
*/
`timescale 1ns/1ps
module dsc_decoder
  import dsc_pkg::*;
#(
  parameter int NCH = `DSC_NCH,
  parameter logic [5:0] CRC_POLY = `DSC_CRC_POLY
) (
  input wire logic mclk_i,                  // System clock, 100 MHz
  input wire logic rst_b_i,                 // Async reset, active low
  input wire logic ce_i,                    // Clock enable, freezes all state
  input wire logic sck_i,                   // Serial clock pin
  input wire logic sdi_i,                   // Serial data in
  input wire logic chip_select_load_n_i,    // Frame select, low while shifting
  input wire logic async_update_pulse_n_i,  // Low pulse updates all channels
  input wire logic [7:0] tsd_status_i,      // Thermal status, same clock
  output logic sdo_o,                       // Serial data out
  output logic [NCH*16-1:0] dac_code_o,     // DAC code registers
  output logic [NCH*12-1:0] dac_set_o,      // DAC settings registers
  output logic [7:0] power_down_o,          // Per channel power-down
  output logic cmd_done_o,                  // Pulse, command executed
  output logic crc_error_o                  // A 32-bit frame failed CRC since the last executed command
);
  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic sck_s, sdi_s, csn_s, ud_s;

  // Reset levels match the idle pins so no false edge follows reset
  dsc_sync #(.W(4), .RST_VAL(4'hc)) u_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .d_i({async_update_pulse_n_i, chip_select_load_n_i, sdi_i, sck_i}),
    .q_o({ud_s, csn_s, sdi_s, sck_s})
  );

  logic sck_q_reg, csn_q_reg, ud_q_reg;
  logic sck_rise, sck_fall, cs_fall, cs_rise, ud_fall;

  assign sck_rise = sck_s & ~sck_q_reg;
  assign sck_fall = ~sck_s & sck_q_reg;
  assign cs_fall = ~csn_s & csn_q_reg;
  assign cs_rise = csn_s & ~csn_q_reg;
  assign ud_fall = ~ud_s & ud_q_reg;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dsc_frame_type st_reg, st_next;
  logic [31:0] shift_reg, shift_next;
  logic [31:0] out_reg, out_next;
  logic [5:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic err_reg, err_next;
  dsc_word_type glob_reg [8];
  dsc_word_type glob_next [8];
  dsc_word_type code_a_reg [NCH];
  dsc_word_type code_a_next [NCH];
  dsc_word_type code_b_reg [NCH];
  dsc_word_type code_b_next [NCH];
  dsc_word_type code_dac_reg [NCH];
  dsc_word_type code_dac_next [NCH];
  dsc_set_type set_in_reg [NCH];
  dsc_set_type set_in_next [NCH];
  dsc_set_type set_dac_reg [NCH];
  dsc_set_type set_dac_next [NCH];
  logic [13:0] ofs_reg [NCH];
  logic [13:0] ofs_next [NCH];
  dsc_word_type gain_reg [NCH];
  dsc_word_type gain_next [NCH];

  // ----------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------
  function automatic logic [5:0] crc6(input logic [25:0] d);
    logic [5:0] c;
    c = '0;
    for (int k = 25; k >= 0; k--) begin
      c = {c[4:0], 1'b0} ^ ((c[5] ^ d[k]) ? CRC_POLY : 6'h00);
    end
    return c;
  endfunction : crc6

  logic [31:0] word;
  logic [7:0] cmd;
  logic [3:0] op;
  dsc_word_type data;
  logic len_ok, crc_ok, exempt, exec;
  logic [NCH-1:0] ch_m;

  assign word = (cnt_reg == `DSC_LEN_LONG) ? shift_reg : {shift_reg[23:0], 8'h00};
  assign cmd = word[31:24];
  assign op = cmd[7:4];
  assign data = word[23:8];
  // Channel numbers 8 to 15 select nothing
  assign ch_m = cmd[3] ? '0 : NCH'(1) << cmd[2:0];
  assign len_ok = cnt_reg == `DSC_LEN_SHORT || cnt_reg == `DSC_LEN_LONG;
  assign exempt = cmd == `DSC_CMD_WR_CFG || cmd == `DSC_CMD_WR_FAULT
               || cmd == `DSC_CMD_RD_CFG || cmd == `DSC_CMD_RD_FAULT;
  assign crc_ok = cnt_reg != `DSC_LEN_LONG || !glob_reg[`DSC_G_CFG][`DSC_CFG_CRC_BIT]
               || exempt || crc6(word[31:6]) == word[5:0];
  assign exec = st_reg == FR_SHIFT && cs_rise && len_ok && crc_ok;

  logic [NCH-1:0] wc_m, ws_m, upd_m;
  dsc_word_type rdata;
  logic is_rd;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    out_next = out_reg;
    done_next = 1'b0;
    err_next = err_reg;
    glob_next = glob_reg;
    code_a_next = code_a_reg;
    code_b_next = code_b_reg;
    code_dac_next = code_dac_reg;
    set_in_next = set_in_reg;
    set_dac_next = set_dac_reg;
    ofs_next = ofs_reg;
    gain_next = gain_reg;
    wc_m = '0;
    ws_m = '0;
    upd_m = '0;
    is_rd = 1'b0;
    rdata = 16'h0000;
    unique case (st_reg)
      FR_IDLE: begin
        if (cs_fall) begin
          st_next = FR_SHIFT;
          cnt_next = '0;
        end
      end
      FR_SHIFT: begin
        if (sck_rise && !csn_s) begin
          shift_next = {shift_reg[30:0], sdi_s};
          cnt_next = (cnt_reg == `DSC_CNT_MAX) ? cnt_reg : cnt_reg + 6'd1;
        end
        // Output moves on the falling edge so the host samples it stable
        if (sck_fall && !csn_s) begin
          out_next = {out_reg[30:0], 1'b0};
        end
        if (cs_rise) begin
          st_next = FR_IDLE;
          if (len_ok && !crc_ok) begin
            err_next = 1'b1;
          end
        end
      end
    endcase
    if (exec) begin
      err_next = 1'b0;
      done_next = 1'b1;
      unique case (op)
        `DSC_OP_WR_CODE: wc_m = ch_m;
        `DSC_OP_WR_SET: ws_m = ch_m;
        `DSC_OP_WR_OFS: begin
          if (!cmd[3]) begin
            ofs_next[cmd[2:0]] = data[15:`DSC_OFS_LSB];
          end
        end
        `DSC_OP_WR_GAIN: begin
          if (!cmd[3]) begin
            gain_next[cmd[2:0]] = data;
          end
        end
        `DSC_OP_WR_UPD: begin
          wc_m = ch_m;
          upd_m = ch_m;
        end
        `DSC_OP_WR_UPD_ALL: begin
          wc_m = ch_m;
          upd_m = '1;
        end
        `DSC_OP_UPD: upd_m = ch_m;
        `DSC_OP_GLOBAL: begin
          if (cmd[3:0] <= `DSC_SUB_LAST_GLOB) begin
            glob_next[cmd[2:0]] = data;
          end
          unique case (cmd[3:0])
            `DSC_SUB_ALL_CODE: wc_m = '1;
            `DSC_SUB_ALL_CODE_UPD: begin
              wc_m = '1;
              upd_m = '1;
            end
            `DSC_SUB_ALL_SET: ws_m = '1;
            `DSC_SUB_ALL_SET_UPD: begin
              ws_m = '1;
              upd_m = '1;
            end
            `DSC_SUB_ALL_UPD: upd_m = '1;
            // Software toggle updates the toggle-enabled channels whose data bit is set
            4'h3: upd_m = data[NCH-1:0] & glob_reg[`DSC_G_TDEN][NCH-1:0];
            default: upd_m = '0;
          endcase
        end
        `DSC_OP_RD_CODE, `DSC_OP_RD_SET, `DSC_OP_RD_OFS, `DSC_OP_RD_GAIN: begin
          is_rd = 1'b1;
          if (!cmd[3]) begin
            unique case (op)
              `DSC_OP_RD_CODE: rdata = code_dac_reg[cmd[2:0]];
              `DSC_OP_RD_SET: rdata = {4'h0, set_in_reg[cmd[2:0]]};
              `DSC_OP_RD_OFS: rdata = {ofs_reg[cmd[2:0]], 2'b00};
              default: rdata = gain_reg[cmd[2:0]];
            endcase
          end
        end
        `DSC_OP_RD_GLOB: begin
          if (!cmd[3]) begin
            is_rd = 1'b1;
            rdata = (cmd[2:0] == `DSC_G_TSD) ? {8'h00, tsd_status_i} : glob_reg[cmd[2:0]];
          end
        end
        default: upd_m = '0;
      endcase
      out_next = is_rd ? {cmd, rdata, 8'h00} : word;
    end
    if (ud_fall) begin
      upd_m = '1;
    end
    for (int i = 0; i < NCH; i++) begin
      if (wc_m[i]) begin
        if (glob_reg[`DSC_G_ABSEL][i]) begin
          code_b_next[i] = data;
        end else begin
          code_a_next[i] = data;
        end
      end
      if (ws_m[i]) begin
        set_in_next[i] = data[`DSC_SET_W-1:0];
      end
      if (upd_m[i]) begin
        // B drives the output only while toggling is on for the channel
        code_dac_next[i] = (glob_next[`DSC_G_TDEN][i] && glob_next[`DSC_G_SWTOG][i])
                         ? code_b_next[i] : code_a_next[i];
        set_dac_next[i] = set_in_next[i];
        glob_next[`DSC_G_PDOWN][i] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_q_reg <= 1'b0;
      csn_q_reg <= 1'b1;
      ud_q_reg <= 1'b1;
      st_reg <= FR_IDLE;
      shift_reg <= '0;
      out_reg <= '0;
      cnt_reg <= '0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        glob_reg[i] <= `DSC_GLOB_RST;
      end
      for (int i = 0; i < NCH; i++) begin
        code_a_reg[i] <= `DSC_CODE_RST;
        code_b_reg[i] <= `DSC_CODE_RST;
        code_dac_reg[i] <= `DSC_CODE_RST;
        set_in_reg[i] <= `DSC_SET_RST;
        set_dac_reg[i] <= `DSC_SET_RST;
        ofs_reg[i] <= `DSC_OFS_RST;
        gain_reg[i] <= `DSC_GAIN_RST;
      end
    end else if (ce_i) begin
      sck_q_reg <= sck_s;
      csn_q_reg <= csn_s;
      ud_q_reg <= ud_s;
      st_reg <= st_next;
      shift_reg <= shift_next;
      out_reg <= out_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      err_reg <= err_next;
      glob_reg <= glob_next;
      code_a_reg <= code_a_next;
      code_b_reg <= code_b_next;
      code_dac_reg <= code_dac_next;
      set_in_reg <= set_in_next;
      set_dac_reg <= set_dac_next;
      ofs_reg <= ofs_next;
      gain_reg <= gain_next;
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      dac_code_o[i*16 +: 16] = code_dac_reg[i];
      dac_set_o[i*12 +: 12] = set_dac_reg[i];
    end
  end

  assign sdo_o = out_reg[31];
  assign power_down_o = glob_reg[`DSC_G_PDOWN][7:0];
  assign cmd_done_o = done_reg;
  assign crc_error_o = err_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  property p_exec_done;
    ce_i && exec |=> done_reg;
  endproperty
  a_exec_done: assert property (p_exec_done) else $error("command not executed");

  property p_len;
    ce_i && st_reg == FR_SHIFT && cs_rise && !len_ok |=> !done_reg;
  endproperty
  a_len: assert property (p_len) else $error("bad length executed");

  property p_shift;
    ce_i && st_reg == FR_SHIFT && sck_rise && !csn_s && cnt_reg < 6'd63
      |=> cnt_reg == $past(cnt_reg) + 6'd1 && shift_reg[0] == $past(sdi_s);
  endproperty
  a_shift: assert property (p_shift) else $error("bit not sampled");

  property p_crc_exempt;
    ce_i && st_reg == FR_SHIFT && cs_rise && cnt_reg == 6'd32 && cmd == 8'h70 |=> done_reg;
  endproperty
  a_crc_exempt: assert property (p_crc_exempt) else $error("config write checked");

  property p_crc_bad;
    ce_i && st_reg == FR_SHIFT && cs_rise && len_ok && !crc_ok
      |=> !done_reg && crc_error_o;
  endproperty
  a_crc_bad: assert property (p_crc_bad) else $error("bad CRC accepted");

  property p_write_hold;
    ce_i && exec && op == 4'h0 && !ud_fall |=> $stable(dac_code_o);
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("write moved output");

  property p_ch_write;
    ce_i && exec && cmd == 8'h03 && !glob_reg[2][3] |=> code_a_reg[3] == $past(data);
  endproperty
  a_ch_write: assert property (p_ch_write) else $error("channel write lost");

  property p_upd_all;
    ce_i && exec && cmd == 8'h79 && glob_reg[4] == 16'h0000 && glob_reg[2] == 16'h0000
      |=> code_dac_reg[0] == $past(data) && code_dac_reg[7] == $past(data);
  endproperty
  a_upd_all: assert property (p_upd_all) else $error("update all failed");

  property p_pd;
    ce_i && exec && cmd == 8'h7c |=> power_down_o == 8'h00;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down kept");

  property p_nop;
    ce_i && exec && cmd == 8'hff && !ud_fall
      |=> $stable(dac_code_o) && $stable(power_down_o) && $stable(dac_set_o);
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state");

  property p_read;
    ce_i && exec && op == 4'h8 |=> out_reg[31:24] == $past(cmd) && out_reg[7:0] == 8'h00;
  endproperty
  a_read: assert property (p_read) else $error("read not loaded");

  c_write_upd: cover property (ce_i && exec && op == 4'h4);
  c_read_glob: cover property (ce_i && exec && op == 4'hf);
  c_crc_fail: cover property (ce_i && cs_rise && len_ok && !crc_ok);
  c_pin_upd: cover property (ce_i && ud_fall);
endmodule : dsc_decoder

// [dsc_defines.svh]
/*
  Constants of the serial command decoder: command codes, word lengths,
  field positions and reset values. Included by the package; the decoder uses its macros.
*/
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

`define DSC_NCH 8
`define DSC_LEN_SHORT 6'd24
`define DSC_LEN_LONG 6'd32
`define DSC_CNT_MAX 6'd63

`define DSC_OP_WR_CODE 4'h0
`define DSC_OP_WR_SET 4'h1
`define DSC_OP_WR_OFS 4'h2
`define DSC_OP_WR_GAIN 4'h3
`define DSC_OP_WR_UPD 4'h4
`define DSC_OP_WR_UPD_ALL 4'h5
`define DSC_OP_UPD 4'h6
`define DSC_OP_GLOBAL 4'h7
`define DSC_OP_RD_CODE 4'h8
`define DSC_OP_RD_SET 4'h9
`define DSC_OP_RD_OFS 4'ha
`define DSC_OP_RD_GAIN 4'hb
`define DSC_OP_RD_GLOB 4'hf

`define DSC_SUB_ALL_CODE 4'h8
`define DSC_SUB_ALL_CODE_UPD 4'h9
`define DSC_SUB_ALL_SET 4'ha
`define DSC_SUB_ALL_SET_UPD 4'hb
`define DSC_SUB_ALL_UPD 4'hc
`define DSC_SUB_LAST_GLOB 4'h6

`define DSC_CMD_WR_CFG 8'h70
`define DSC_CMD_WR_FAULT 8'h76
`define DSC_CMD_RD_CFG 8'hf0
`define DSC_CMD_RD_FAULT 8'hf6

`define DSC_G_CFG 3'h0
`define DSC_G_PDOWN 3'h1
`define DSC_G_ABSEL 3'h2
`define DSC_G_SWTOG 3'h3
`define DSC_G_TDEN 3'h4
`define DSC_G_TSD 3'h7

`define DSC_CFG_CRC_BIT 0
`define DSC_SET_W 12
`define DSC_OFS_LSB 2

`define DSC_CODE_RST 16'h0000
`define DSC_SET_RST 12'h000
`define DSC_OFS_RST 14'h0000
`define DSC_GAIN_RST 16'h0000
`define DSC_GLOB_RST 16'h0000
`define DSC_CRC_POLY 6'h03

`endif

// [dsc_host_model.sv]
/*
  Host serial controller model for the command decoder bench.
  Assumes the decoder samples sdi on rising sck and shifts sdo on falling sck.
*/
`timescale 1ns/1ps
module dsc_host_model (
  output logic sck_o,             // Serial clock, idle low
  output logic sdi_o,             // Serial data to the decoder
  output logic chip_select_load_n_o, // Frame select, low while shifting
  input wire logic sdo_i          // Serial data from the decoder
);
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    chip_select_load_n_o = 1'b1;
  end

  // ----------------------------------------
  // One frame of n bits, 80 ns serial period
  // ----------------------------------------
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rx);
    rx = 32'h0000_0000;
    chip_select_load_n_o = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      sdi_o = w[31-i];
      #40 sck_o = 1'b1;
      // Sample late in the high phase; sdo changes only after the fall
      #39 rx[31-i] = sdo_i;
      #1 sck_o = 1'b0;
    end
    #40 chip_select_load_n_o = 1'b1;
    // Released line must not keep the last bit
    sdi_o = ~sdi_o;
  endtask : xfer
endmodule : dsc_host_model

// [dsc_pkg.sv]
/*
  Types shared by the decoder files.
  Assumes dsc_defines.svh is on the include path.
*/
package dsc_pkg;
  `include "dsc_defines.svh"

  typedef logic [15:0] dsc_word_type;
  typedef logic [`DSC_SET_W-1:0] dsc_set_type;
  typedef enum logic {FR_IDLE, FR_SHIFT} dsc_frame_type;
endpackage : dsc_pkg

// [dsc_sync.sv]
/*
  Two flip-flop synchroniser for pins from outside the mclk domain.
  Assumes a clock enable that freezes it together with the decoder.
*/
`timescale 1ns/1ps
module dsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk_i,           // System clock
  input wire logic rst_b_i,          // Async reset, active low
  input wire logic ce_i,             // Clock enable
  input wire logic [W-1:0] d_i,      // Raw pin levels
  output logic [W-1:0] q_o           // Synchronised levels
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = ce_i ? d_i : meta_reg;
    q_next = ce_i ? meta_reg : q_reg;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule : dsc_sync

// [tb_top.sv]
/*
  Self-checking bench for the serial command decoder.
  Assumes the host model drives the link and the bench drives the other pins.
*/
`timescale 1ns/1ps
module tb_top;
  import dsc_pkg::*;
  localparam logic [5:0] POLY = 6'h03;
  logic mclk_i, rst_b_i, ce_i, async_update_pulse_n_i;
  logic [7:0] tsd_status_i;
  logic sck, sdi, cs_n, sdo_o, cmd_done_o, crc_error_o;
  logic [127:0] dac_code_o;
  logic [95:0] dac_set_o;
  logic [7:0] power_down_o;
  logic [31:0] rx;
  int err_count = 0;
  int samples_checked = 0;
  int done_cnt = 0;

  dsc_decoder #(.CRC_POLY(POLY)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .sck_i(sck), .sdi_i(sdi), .chip_select_load_n_i(cs_n),
    .async_update_pulse_n_i(async_update_pulse_n_i), .tsd_status_i(tsd_status_i),
    .sdo_o(sdo_o), .dac_code_o(dac_code_o), .dac_set_o(dac_set_o),
    .power_down_o(power_down_o), .cmd_done_o(cmd_done_o), .crc_error_o(crc_error_o));
  dsc_host_model host (.sck_o(sck), .sdi_o(sdi), .chip_select_load_n_o(cs_n), .sdo_i(sdo_o));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) if (cmd_done_o === 1'b1) done_cnt <= done_cnt + 1;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  function automatic logic [5:0] crc6(input logic [31:0] w);
    logic [5:0] c;
    logic fb;
    c = 6'h00;
    for (int i = 31; i >= 6; i--) begin
      fb = c[5] ^ w[i];
      c = {c[4:0], 1'b0} ^ (fb ? POLY : 6'h00);
    end
    return c;
  endfunction : crc6

  task automatic run(input logic [7:0] cmd, input logic [15:0] data, input logic [7:0] low,
                     input int n, input int pulses);
    int d0;
    // Host edges fall 1 ns after mclk edges, never on them
    @(posedge mclk_i);
    #1;
    d0 = done_cnt;
    host.xfer({cmd, data, low}, n, rx);
    repeat (12) @(posedge mclk_i);
    check(done_cnt - d0, pulses, "command pulses");
  endtask : run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_write_update;
    run(8'h03, 16'h1234, 8'h00, 32, 1);
    check(dac_code_o, 128'h0, "code before update");
    run(8'h63, 16'hffff, 8'h00, 32, 1);
    check(dac_code_o, 128'h1234 << 48, "code after update");
    check(rx, 32'h0312_3400, "echo of write");
    check(dac_set_o, 96'h0, "span untouched");
    $display("test write_update done");
  endtask : t_write_update

  task automatic t_settings;
    run(8'h15, 16'h0abc, 8'h00, 32, 1);
    check(dac_set_o, 96'h0, "settings before update");
    run(8'h45, 16'habcd, 8'h00, 32, 1);
    check(dac_code_o[95:80], 16'habcd, "write and update");
    check(dac_set_o, 96'habc << 60, "span moved with code");
    $display("test settings done");
  endtask : t_settings

  task automatic t_all_read;
    tsd_status_i = 8'h5a;
    run(8'h79, 16'h5555, 8'h00, 32, 1);
    check(dac_code_o, {8{16'h5555}}, "write and update all");
    run(8'h83, 16'hffff, 8'h00, 32, 1);
    run(8'h95, 16'hffff, 8'h00, 32, 1);
    check(rx, 32'h8355_5500, "read code");
    run(8'hf7, 16'h0000, 8'h00, 32, 1);
    check(rx, 32'h950a_bc00, "read settings");
    run(8'hff, 16'h1234, 8'h00, 32, 1);
    check(rx, 32'hf700_5a00, "read thermal status");
    check(dac_code_o, {8{16'h5555}}, "no operation");
    $display("test all_read done");
  endtask : t_all_read

  task automatic t_pdown;
    run(8'h71, 16'h00ff, 8'h00, 32, 1);
    check(power_down_o, 8'hff, "power-down write");
    run(8'h62, 16'h0000, 8'h00, 32, 1);
    check(power_down_o, 8'hfb, "update wakes channel");
    $display("test pdown done");
  endtask : t_pdown

  task automatic t_refuse;
    logic [127:0] snap;
    snap = dac_code_o;
    run(8'h7d, 16'h1111, 8'h00, 32, 1);
    run(8'h00, 16'hffff, 8'h00, 16, 0);
    run(8'h0b, 16'h2222, 8'h00, 32, 1);
    run(8'h7c, 16'h0000, 8'h00, 32, 1);
    check(dac_code_o, snap, "refused frames change nothing");
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_pin;
    run(8'h00, 16'h0f0f, 8'h00, 24, 1);
    check(dac_code_o[15:0], 16'h5555, "short write held");
    // Clock enable low freezes the synchronisers, so this pulse is lost
    @(posedge mclk_i) #1 ce_i = 1'b0;
    async_update_pulse_n_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 async_update_pulse_n_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1 ce_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    check(dac_code_o[15:0], 16'h5555, "pulse ignored while frozen");
    @(posedge mclk_i) #1 async_update_pulse_n_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 async_update_pulse_n_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    check(dac_code_o[15:0], 16'h0f0f, "pin update");
    $display("test pin done");
  endtask : t_pin

  task automatic t_crc;
    logic [5:0] c;
    c = crc6({8'h41, 16'h7777, 8'h00});
    run(8'h70, 16'h0001, 8'h3f, 32, 1);
    run(8'h41, 16'h7777, {2'b00, c ^ 6'h01}, 32, 0);
    check(crc_error_o, 1'b1, "bad check code flagged");
    check(dac_code_o[31:16], 16'h5555, "bad frame dropped");
    run(8'h41, 16'h7777, {2'b00, c}, 32, 1);
    check(dac_code_o[31:16], 16'h7777, "good check code");
    check(crc_error_o, 1'b0, "error cleared");
    run(8'h41, 16'h6666, 8'h00, 24, 1);
    check(dac_code_o[31:16], 16'h6666, "short word skips check");
    run(8'h70, 16'h0000, 8'h15, 32, 1);
    $display("test crc done");
  endtask : t_crc

  task automatic t_adjust;
    run(8'h26, 16'h1237, 8'h00, 32, 1);
    run(8'h37, 16'hbeef, 8'h00, 32, 1);
    check(dac_code_o[111:96], 16'h5555, "adjust leaves output");
    run(8'ha6, 16'hffff, 8'h00, 32, 1);
    check(rx, 32'h37be_ef00, "echo of gain write");
    run(8'hb7, 16'hffff, 8'h00, 32, 1);
    check(rx, 32'ha612_3400, "read offset");
    run(8'hff, 16'h0000, 8'h00, 32, 1);
    check(rx, 32'hb7be_ef00, "read gain");
    $display("test adjust done");
  endtask : t_adjust

  task automatic t_toggle;
    run(8'h72, 16'h0010, 8'h00, 32, 1);
    run(8'h44, 16'h4444, 8'h00, 32, 1);
    check(dac_code_o[79:64], 16'h5555, "B unused without toggle");
    run(8'h74, 16'h0010, 8'h00, 32, 1);
    run(8'h73, 16'h0010, 8'h00, 32, 1);
    check(dac_code_o[79:64], 16'h4444, "software toggle selects B");
    $display("test toggle done");
  endtask : t_toggle

  initial begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    async_update_pulse_n_i = 1'b1;
    tsd_status_i = 8'h00;
    repeat (8) @(posedge mclk_i);
    #1 rst_b_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    check(dac_code_o, 128'h0, "reset codes");
    check(power_down_o, 8'h00, "reset power-down");
    check(dac_set_o, 96'h0, "reset settings");
    t_write_update;
    t_settings;
    t_all_read;
    t_pdown;
    t_refuse;
    t_pin;
    t_crc;
    t_adjust;
    t_toggle;
    close_out;
  end

  // Frames take about 3 us each; far more than the whole sequence needs
  initial begin
    #500us;
    err_count++;
    close_out;
  end
endmodule : tb_top
